/* pcsg_consts.vh */
// register map, field positions and reset values of the socket zero gating block
`ifndef PCSG_CONSTS_VH
`define PCSG_CONSTS_VH

// register byte offsets
`define PCSG_CTRL_OFFSET 8'h00
`define PCSG_SLEEP_OFFSET 8'h04
`define PCSG_STATUS_OFFSET 8'h08
`define PCSG_ADDR_BITS 8

// socket_control_reg fields
`define PCSG_CTRL_WIDTH 6
`define PCSG_CTRL_EN_BIT 2
`define PCSG_CTRL_RESET 6'h00

// socket_sleep_state_reg fields
`define PCSG_SLEEP_WIDTH 2
`define PCSG_SLEEP_S0_BIT 0
`define PCSG_SLEEP_RESET 2'h0

// status register fields
`define PCSG_STAT_CD_LSB 0
`define PCSG_STAT_SLEEP_BIT 2

// socket bus widths
`define PCSG_ADDR_WIDTH 26
`define PCSG_DATA_WIDTH 16
`define PCSG_NUM_STROBES 6

// htrans nonseq bit, hresp okay
`define PCSG_HTRANS_ACTIVE_BIT 1
`define PCSG_HRESP_OKAY 1'b0

`endif

/* pcsg_socket0.v */
// socket zero gating of a pc card interface with its ahb-lite register slave
`timescale 1ns/100ps
`include "pcsg_consts.vh"

module pcsg_socket0 (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire sleep_mode,
  input wire host_socket_select,
  input wire [1:0] host_card_enable_n,
  input wire host_output_enable_n,
  input wire host_write_enable_n,
  input wire host_io_read_n,
  input wire host_reg_select_n,
  input wire [25:0] host_address,
  input wire [15:0] host_data_out,
  output wire [15:0] host_data_in,
  input wire [1:0] sock0_card_detect_n,
  output wire [25:0] sock0_address_bus,
  output wire sock0_address_oe,
  input wire [15:0] sock0_data_bus_in,
  output wire [15:0] sock0_data_bus_out,
  output wire sock0_data_bus_oe,
  output wire [1:0] sock0_card_enable_n,
  output wire [1:0] sock0_card_enable_oe,
  output wire sock0_output_enable_n,
  output wire sock0_output_enable_oe,
  output wire sock0_write_enable_n,
  output wire sock0_write_enable_oe,
  output wire sock0_io_read_n,
  output wire sock0_io_read_oe,
  output wire sock0_reg_select_n,
  output wire sock0_reg_select_oe
);

  // strobe bit order: ce[0], ce[1], oe, we, ior, reg
  localparam NS = `PCSG_NUM_STROBES;
  localparam AW = `PCSG_ADDR_WIDTH;
  localparam DW = `PCSG_DATA_WIDTH;

  // strobe gating: returns {drive, level}
  function [1:0] pcsg_strobe;
    input en;
    input slp;
    input sst;
    input pass;
    input host_n;
    begin
      if (!en) begin
        pcsg_strobe = 2'b00;
      end else if (slp) begin
        pcsg_strobe = sst ? 2'b11 : 2'b00;
      end else if (pass) begin
        pcsg_strobe = {1'b1, host_n};
      end else begin
        pcsg_strobe = 2'b11;
      end
    end
  endfunction

  // register select match in the address phase
  function pcsg_hit;
    input [31:0] a;
    input [7:0] off;
    begin
      pcsg_hit = (a[`PCSG_ADDR_BITS-1:0] == off);
    end
  endfunction

  // two-stage synchronisers for pins
  reg [NS-1:0] strobe_meta_reg;
  reg [NS-1:0] strobe_sync_reg;
  reg [1:0] cd_meta_reg;
  reg [1:0] cd_sync_reg;
  reg sel_meta_reg;
  reg sel_sync_reg;
  reg sleep_meta_reg;
  reg sleep_sync_reg;
  reg [AW-1:0] addr_meta_reg;
  reg [AW-1:0] addr_sync_reg;
  reg [DW-1:0] hdata_meta_reg;
  reg [DW-1:0] hdata_sync_reg;
  reg [DW-1:0] sdata_meta_reg;
  reg [DW-1:0] sdata_sync_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe_meta_reg <= 6'h3f;
      strobe_sync_reg <= 6'h3f;
      cd_meta_reg <= 2'h3;
      cd_sync_reg <= 2'h3;
      sel_meta_reg <= 1'b0;
      sel_sync_reg <= 1'b0;
      sleep_meta_reg <= 1'b0;
      sleep_sync_reg <= 1'b0;
      addr_meta_reg <= 26'h0000000;
      addr_sync_reg <= 26'h0000000;
      hdata_meta_reg <= 16'h0000;
      hdata_sync_reg <= 16'h0000;
      sdata_meta_reg <= 16'h0000;
      sdata_sync_reg <= 16'h0000;
    end else begin
      strobe_meta_reg <= {host_reg_select_n, host_io_read_n, host_write_enable_n,
                          host_output_enable_n, host_card_enable_n};
      strobe_sync_reg <= strobe_meta_reg;
      cd_meta_reg <= sock0_card_detect_n;
      cd_sync_reg <= cd_meta_reg;
      sel_meta_reg <= host_socket_select;
      sel_sync_reg <= sel_meta_reg;
      sleep_meta_reg <= sleep_mode;
      sleep_sync_reg <= sleep_meta_reg;
      addr_meta_reg <= host_address;
      addr_sync_reg <= addr_meta_reg;
      hdata_meta_reg <= host_data_out;
      hdata_sync_reg <= hdata_meta_reg;
      sdata_meta_reg <= sock0_data_bus_in;
      sdata_sync_reg <= sdata_meta_reg;
    end
  end

  // software registers
  reg [`PCSG_CTRL_WIDTH-1:0] socket_control_reg;
  reg [`PCSG_SLEEP_WIDTH-1:0] socket_sleep_state_reg;

  // ahb-lite slave, zero wait states
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  reg [31:0] hrdata_reg;
  reg hreadyout_reg;
  reg hresp_reg;
  reg [31:0] rd_next;
  wire take = hsel && hready && htrans[`PCSG_HTRANS_ACTIVE_BIT];

  always @* begin
    rd_next = 32'h00000000;
    if (pcsg_hit(haddr, `PCSG_CTRL_OFFSET)) begin
      rd_next[`PCSG_CTRL_WIDTH-1:0] = socket_control_reg;
    end else if (pcsg_hit(haddr, `PCSG_SLEEP_OFFSET)) begin
      rd_next[`PCSG_SLEEP_WIDTH-1:0] = socket_sleep_state_reg;
    end else if (pcsg_hit(haddr, `PCSG_STATUS_OFFSET)) begin
      rd_next[`PCSG_STAT_CD_LSB+1:`PCSG_STAT_CD_LSB] = cd_sync_reg;
      rd_next[`PCSG_STAT_SLEEP_BIT] = sleep_sync_reg;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b0;
      hresp_reg <= `PCSG_HRESP_OKAY;
      socket_control_reg <= `PCSG_CTRL_RESET;
      socket_sleep_state_reg <= `PCSG_SLEEP_RESET;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= `PCSG_HRESP_OKAY;
      wr_pend_reg <= take && hwrite;
      if (take) begin
        wr_addr_reg <= haddr[`PCSG_ADDR_BITS-1:0];
      end
      if (take && !hwrite) begin
        hrdata_reg <= rd_next;
      end
      if (wr_pend_reg && wr_addr_reg == `PCSG_CTRL_OFFSET) begin
        socket_control_reg <= hwdata[`PCSG_CTRL_WIDTH-1:0];
      end
      if (wr_pend_reg && wr_addr_reg == `PCSG_SLEEP_OFFSET) begin
        socket_sleep_state_reg <= hwdata[`PCSG_SLEEP_WIDTH-1:0];
      end
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;

  // decoded socket conditions
  wire en = socket_control_reg[`PCSG_CTRL_EN_BIT];
  wire sst = socket_sleep_state_reg[`PCSG_SLEEP_S0_BIT];
  wire slp = sleep_sync_reg;
  wire cd_ok = (cd_sync_reg == 2'b00);
  wire pass = cd_ok && !sel_sync_reg;

  // strobe and card-enable outputs, one flop pair per strobe
  wire [NS-1:0] strobe_q;
  wire [NS-1:0] strobe_oe_q;
  genvar i;
  generate
    for (i = 0; i < NS; i = i + 1) begin : g_strobe
      wire [1:0] s = pcsg_strobe(en, slp, sst, pass, strobe_sync_reg[i]);
      reg lvl_reg;
      reg oe_reg;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          lvl_reg <= 1'b1;
          oe_reg <= 1'b0;
        end else begin
          lvl_reg <= s[0];
          oe_reg <= s[1];
        end
      end
      assign strobe_q[i] = lvl_reg;
      assign strobe_oe_q[i] = oe_reg;
    end
  endgenerate

  assign sock0_card_enable_n = strobe_q[1:0];
  assign sock0_card_enable_oe = strobe_oe_q[1:0];
  assign sock0_output_enable_n = strobe_q[2];
  assign sock0_output_enable_oe = strobe_oe_q[2];
  assign sock0_write_enable_n = strobe_q[3];
  assign sock0_write_enable_oe = strobe_oe_q[3];
  assign sock0_io_read_n = strobe_q[4];
  assign sock0_io_read_oe = strobe_oe_q[4];
  assign sock0_reg_select_n = strobe_q[5];
  assign sock0_reg_select_oe = strobe_oe_q[5];

  // address and data gating
  reg [AW-1:0] addr_reg;
  reg addr_oe_reg;
  reg [DW-1:0] data_reg;
  reg data_oe_reg;
  reg [DW-1:0] hdin_reg;
  reg [AW-1:0] addr_next;
  reg addr_oe_next;
  reg [DW-1:0] data_next;
  reg data_oe_next;
  wire host_reading = !strobe_sync_reg[4] || !strobe_sync_reg[2];

  always @* begin
    addr_next = {AW{1'b0}};
    addr_oe_next = 1'b0;
    if (!cd_ok || !en) begin
      addr_oe_next = 1'b0;
    end else if (slp) begin
      addr_oe_next = sst;
    end else if (sel_sync_reg || strobe_sync_reg[1:0] == 2'b11) begin
      addr_oe_next = 1'b1;
    end else begin
      addr_oe_next = 1'b1;
      addr_next = addr_sync_reg;
    end
  end

  always @* begin
    data_next = {DW{1'b0}};
    data_oe_next = 1'b0;
    if (!en) begin
      data_oe_next = 1'b0;
    end else if (slp) begin
      data_oe_next = sst;
    end else if (host_reading && !sel_sync_reg) begin
      data_oe_next = 1'b0;
    end else begin
      data_oe_next = 1'b1;
      data_next = hdata_sync_reg;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 26'h0000000;
      addr_oe_reg <= 1'b0;
      data_reg <= 16'h0000;
      data_oe_reg <= 1'b0;
      hdin_reg <= 16'h0000;
    end else begin
      addr_reg <= addr_next;
      addr_oe_reg <= addr_oe_next;
      data_reg <= data_next;
      data_oe_reg <= data_oe_next;
      hdin_reg <= sdata_sync_reg;
    end
  end

  assign sock0_address_bus = addr_reg;
  assign sock0_address_oe = addr_oe_reg;
  assign sock0_data_bus_out = data_reg;
  assign sock0_data_bus_oe = data_oe_reg;
  assign host_data_in = hdin_reg;

endmodule // pcsg_socket0

/* pcsg_socket0_props.sv */
// concurrent checks on the socket zero pins of the gating block
`timescale 1ns/100ps
module pcsg_props (
  input wire hclk,
  input wire hresetn,
  input wire sleep_mode,
  input wire host_socket_select,
  input wire [1:0] host_card_enable_n,
  input wire host_output_enable_n,
  input wire host_io_read_n,
  input wire [15:0] host_data_out,
  input wire [1:0] sock0_card_detect_n,
  input wire [25:0] sock0_address_bus,
  input wire sock0_address_oe,
  input wire [15:0] sock0_data_bus_out,
  input wire sock0_data_bus_oe,
  input wire [1:0] sock0_card_enable_n,
  input wire [1:0] sock0_card_enable_oe,
  input wire sock0_output_enable_n,
  input wire sock0_output_enable_oe,
  input wire sock0_write_enable_n,
  input wire sock0_write_enable_oe,
  input wire sock0_io_read_n,
  input wire sock0_io_read_oe,
  input wire sock0_reg_select_n,
  input wire sock0_reg_select_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire ooe = sock0_output_enable_oe;
  wire [5:0] stv = {sock0_card_enable_n, sock0_output_enable_n, sock0_write_enable_n, sock0_io_read_n,
    sock0_reg_select_n};
  property p_oe_same;
    {sock0_card_enable_oe, sock0_write_enable_oe, sock0_io_read_oe, sock0_reg_select_oe} == {5{ooe}};
  endproperty
  a_oe_same: assert property (p_oe_same) else $error("control enables differ");
  property p_addr_cd;
    $past(sock0_card_detect_n, 3) != 2'h0 |-> !sock0_address_oe;
  endproperty
  a_addr_cd: assert property (p_addr_cd) else $error("address driven without card");
  property p_addr_slp;
    sock0_address_oe && $past(sleep_mode, 3) |-> sock0_address_bus == 26'h0;
  endproperty
  a_addr_slp: assert property (p_addr_slp) else $error("sleep address not low");
  property p_addr_low;
    sock0_address_oe && ($past(host_socket_select, 3) || $past(host_card_enable_n, 3) == 2'h3)
      |-> sock0_address_bus == 26'h0;
  endproperty
  a_addr_low: assert property (p_addr_low) else $error("address not forced low");
  property p_data_slp;
    sock0_data_bus_oe && $past(sleep_mode, 3) |-> sock0_data_bus_out == 16'h0;
  endproperty
  a_data_slp: assert property (p_data_slp) else $error("sleep data not low");
  property p_data_wake;
    sock0_data_bus_oe && !$past(sleep_mode, 3) |-> sock0_data_bus_out == $past(host_data_out, 3) &&
      ($past(host_socket_select, 3) || ($past(host_output_enable_n, 3) && $past(host_io_read_n, 3)));
  endproperty
  a_data_wake: assert property (p_data_wake) else $error("data drive wrong");
  property p_strb_slp;
    ooe && $past(sleep_mode, 3) |-> stv == 6'h3f;
  endproperty
  a_strb_slp: assert property (p_strb_slp) else $error("sleep strobes not high");
  property p_pass;
    ooe && !$past(sleep_mode, 3) && $past(sock0_card_detect_n, 3) == 2'h0 && !$past(host_socket_select, 3)
      |-> sock0_output_enable_n == $past(host_output_enable_n, 3) && sock0_card_enable_n == $past(host_card_enable_n, 3);
  endproperty
  a_pass: assert property (p_pass) else $error("strobe not passed");
  property p_block;
    ooe && !$past(sleep_mode, 3) && ($past(sock0_card_detect_n, 3) != 2'h0 || $past(host_socket_select, 3))
      |-> stv == 6'h3f;
  endproperty
  a_block: assert property (p_block) else $error("blocked strobes not high");
  c_pass: cover property (ooe && !sock0_output_enable_n);
  c_slp: cover property (ooe && $past(sleep_mode, 3));
  c_addr: cover property (sock0_address_oe && sock0_address_bus != 26'h0);
endmodule // pcsg_props
bind pcsg_socket0 pcsg_props u_pcsg_props (.hclk, .hresetn, .sleep_mode, .host_socket_select, .host_card_enable_n,
  .host_output_enable_n, .host_io_read_n, .host_data_out, .sock0_card_detect_n, .sock0_address_bus,
  .sock0_address_oe, .sock0_data_bus_out, .sock0_data_bus_oe, .sock0_card_enable_n, .sock0_card_enable_oe,
  .sock0_output_enable_n, .sock0_output_enable_oe, .sock0_write_enable_n, .sock0_write_enable_oe,
  .sock0_io_read_n, .sock0_io_read_oe, .sock0_reg_select_n, .sock0_reg_select_oe);

/* pcsg_card_model.sv */
// behavioural pc card in socket zero, answering reads per byte lane
`timescale 1ns/100ps
module pcsg_card_model (
  input wire hclk,
  input wire [1:0] ce_n,
  input wire oe_n,
  input wire ior_n,
  input wire [15:0] word,
  output reg [15:0] data
);
  reg [15:0] fill = 16'h0;
  wire rd = !oe_n || !ior_n;
  // undriven lanes show a moving pattern
  always @(posedge hclk) begin
    fill <= fill + 16'h1357;
  end
  // lane 1 high byte, lane 0 low byte, 16-bit path
  always @* begin
    data[15:8] = (rd && !ce_n[1]) ? word[15:8] : fill[15:8];
    data[7:0] = (rd && !ce_n[0]) ? word[7:0] : fill[7:0];
  end
endmodule // pcsg_card_model

/* tb_top.sv */
// self-checking bench of the socket zero gating block
`timescale 1ns/100ps
module tb_top;
  reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slp = 0, sel = 0, hoe = 1, hwe = 1, hior = 1, hreg = 1;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  reg [1:0] htrans = 2'h0, hce = 2'h3, cd = 2'h0;
  reg [25:0] ha = 26'h0;
  reg [15:0] hdo = 16'h0;
  integer err_total = 0, num_checks = 0;
  wire hreadyout, hresp, aoe, doe, soe, swe, sior, sreg, ooe, weo, ioo, rgo;
  wire [31:0] hrdata;
  wire [15:0] hdi, dout, cdat, din;
  wire [25:0] sa;
  wire [1:0] sce, sceo;
  wire [7:0] oes = {aoe, doe, sceo, ooe, weo, ioo, rgo};
  wire [5:0] stv = {sce, soe, swe, sior, sreg};
  assign din = doe ? dout : cdat;
  always #4 hclk = ~hclk;
  pcsg_socket0 u_pcsg_socket0 (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sleep_mode(slp), .host_socket_select(sel), .host_card_enable_n(hce),
    .host_output_enable_n(hoe), .host_write_enable_n(hwe), .host_io_read_n(hior), .host_reg_select_n(hreg),
    .host_address(ha), .host_data_out(hdo), .host_data_in(hdi), .sock0_card_detect_n(cd),
    .sock0_address_bus(sa), .sock0_address_oe(aoe), .sock0_data_bus_in(din), .sock0_data_bus_out(dout),
    .sock0_data_bus_oe(doe), .sock0_card_enable_n(sce), .sock0_card_enable_oe(sceo),
    .sock0_output_enable_n(soe), .sock0_output_enable_oe(ooe), .sock0_write_enable_n(swe),
    .sock0_write_enable_oe(weo), .sock0_io_read_n(sior), .sock0_io_read_oe(ioo), .sock0_reg_select_n(sreg),
    .sock0_reg_select_oe(rgo));
  // floated strobes read as pulled up at the card
  pcsg_card_model u_pcsg_card_model (.hclk(hclk), .ce_n(sce | ~sceo), .oe_n(soe | ~ooe), .ior_n(sior | ~ioo),
    .word(16'h6b2d), .data(cdat));
  task chk(input [31:0] g, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task ahb(input w, input [7:0] a, input [31:0] wd);
    begin
      @(posedge hclk);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
    end
  endtask
  task settle;
    repeat (5) @(posedge hclk);
  endtask
  task t_reset;
    begin
      ahb(0, 8'h00, 0); chk(rd, 32'h0);
      ahb(0, 8'h04, 0); chk(rd, 32'h0);
      ahb(0, 8'h08, 0); chk(rd, 32'h0);
      ahb(1, 8'h0c, 32'h5); ahb(0, 8'h0c, 0); chk(rd, 32'h0);
      chk(oes, 8'h0);
      chk(hresp, 1'b0);
      $display("reset test done");
    end
  endtask
  task t_pass;
    begin
      ahb(1, 8'h00, 32'h4);
      @(posedge hclk);
      hce <= 2'h1; hoe <= 0; hwe <= 0; hreg <= 0; ha <= 26'h15a5a5a; hdo <= 16'hc3a5;
      settle;
      chk(oes, 8'hbf);
      chk(stv, 6'h12);
      chk(sa, 26'h15a5a5a);
      @(posedge hclk);
      hoe <= 1; hwe <= 1; hreg <= 1;
      settle;
      chk(doe, 1'b1);
      chk(dout, 16'hc3a5);
      @(posedge hclk);
      hce <= 2'h2; hior <= 0;
      repeat (8) @(posedge hclk);
      chk(doe, 1'b0);
      chk(sior, 1'b0);
      chk(hdi[7:0], 8'h2d);
      @(posedge hclk);
      hce <= 2'h1;
      repeat (8) @(posedge hclk);
      chk(sce, 2'h1);
      chk(hdi[15:8], 8'h6b);
      @(posedge hclk);
      hior <= 1;
      $display("pass test done");
    end
  endtask
  task t_block;
    begin
      @(posedge hclk); sel <= 1; settle;
      chk(stv, 6'h3f); chk(sa, 26'h0);
      @(posedge hclk); sel <= 0; cd <= 2'h1; settle;
      chk(aoe, 1'b0); chk(stv, 6'h3f);
      @(posedge hclk); cd <= 2'h0; hce <= 2'h3; settle;
      chk(aoe, 1'b1); chk(sa, 26'h0);
      $display("block test done");
    end
  endtask
  task t_sleep;
    begin
      @(posedge hclk); slp <= 1; settle;
      chk(oes, 8'h0);
      ahb(1, 8'h04, 32'h1); settle;
      chk(oes, 8'hff); chk(stv, 6'h3f);
      chk(sa, 26'h0); chk(dout, 16'h0);
      ahb(0, 8'h08, 0); chk(rd, 32'h4);
      @(posedge hclk); slp <= 0;
      ahb(1, 8'h00, 32'h0); settle;
      chk(oes, 8'h0);
      $display("sleep test done");
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #200000;
    err_total = err_total + 1;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    t_reset;
    t_pass;
    t_block;
    t_sleep;
    complete_run;
  end
endmodule // tb_top
